// ---- inc/rmpd_pkg.sv ----
// constants and types for the register/memory and product decode block
package rmpd_pkg;

  // ----------------------------------------------------------------
  // opcodes and mode nibbles
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_PRODUCT = 8'h42;
  localparam logic [3:0] NIB_IMM     = 4'ha;
  localparam logic [3:0] NIB_DIR     = 4'hb;
  localparam logic [3:0] NIB_EXT     = 4'hc;
  localparam logic [3:0] NIB_IX2     = 4'hd;
  localparam logic [3:0] NIB_IX1     = 4'he;
  localparam logic [3:0] NIB_IX0     = 4'hf;

  // ----------------------------------------------------------------
  // lengths and cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] LEN_ONE   = 2'd1;
  localparam logic [1:0] LEN_TWO   = 2'd2;
  localparam logic [1:0] LEN_THREE = 2'd3;
  localparam logic [3:0] CYC_IMM   = 4'd2;
  localparam logic [3:0] CYC_DIR   = 4'd3;
  localparam logic [3:0] CYC_EXT   = 4'd4;
  localparam logic [3:0] CYC_IX2   = 4'd5;
  localparam logic [3:0] CYC_IX1   = 4'd4;
  localparam logic [3:0] CYC_IX0   = 4'd3;
  localparam logic [3:0] CYC_PRODUCT = 4'd11;
  localparam logic [3:0] CYC_STORE_ADD = 4'd1;
  localparam logic [3:0] CYC_JUMP_SUB  = 4'd1;
  localparam logic [3:0] CYC_CALL_ADD  = 4'd2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ACC    = 8'h00;
  localparam logic [7:0] RST_IDX    = 8'h00;
  localparam logic       RST_MASK   = 1'b1;
  localparam logic       RST_FLAG   = 1'b0;

  typedef enum logic [4:0] {
    RMPD_SUB     = 5'h00,
    RMPD_CMPA    = 5'h01,
    RMPD_SBWB    = 5'h02,
    RMPD_CMPX    = 5'h03,
    RMPD_AND     = 5'h04,
    RMPD_ANDTST  = 5'h05,
    RMPD_LDACC   = 5'h06,
    RMPD_STACC   = 5'h07,
    RMPD_XOR     = 5'h08,
    RMPD_ADWC    = 5'h09,
    RMPD_OR      = 5'h0a,
    RMPD_ADD     = 5'h0b,
    RMPD_JUMP    = 5'h0c,
    RMPD_CALL    = 5'h0d,
    RMPD_LDIDX   = 5'h0e,
    RMPD_STIDX   = 5'h0f,
    RMPD_PRODUCT = 5'h10
  } rmpd_op_t;

endpackage

// ---- inc/rmpd_dec_if.sv ----
// decoder request and answer carried between the decoder and the executor
`timescale 1ns/1ps
interface rmpd_dec_if;
  logic [7:0]        opcode;
  logic              legal;
  logic [1:0]        len;
  logic [3:0]        cycles;
  rmpd_pkg::rmpd_op_t op;

  modport dec (input opcode, output legal, output len, output cycles, output op);
  modport exe (output opcode, input legal, input len, input cycles, input op);
endinterface

// ---- design/rmpd_decode.sv ----
// opcode decoder: operation, length and cycle count
`timescale 1ns/1ps
module rmpd_decode (
  rmpd_dec_if.dec d
);

  logic [3:0] hi;
  logic [3:0] lo;
  logic [3:0] base;

  assign hi = d.opcode[7:4];
  assign lo = d.opcode[3:0];

  always_comb begin
    d.legal  = 1'b1;
    d.len    = rmpd_pkg::LEN_TWO;
    base     = rmpd_pkg::CYC_IMM;
    d.op     = rmpd_pkg::rmpd_op_t'({1'b0, lo});
    d.cycles = rmpd_pkg::CYC_IMM;
    unique case (hi)
      rmpd_pkg::NIB_IMM: begin
        base  = rmpd_pkg::CYC_IMM;
        d.len = rmpd_pkg::LEN_TWO;
        if (lo == 4'h7 || lo == 4'hc || lo == 4'hd || lo == 4'hf) begin
          d.legal = 1'b0;
        end
      end
      rmpd_pkg::NIB_DIR: begin
        base  = rmpd_pkg::CYC_DIR;
        d.len = rmpd_pkg::LEN_TWO;
      end
      rmpd_pkg::NIB_EXT: begin
        base  = rmpd_pkg::CYC_EXT;
        d.len = rmpd_pkg::LEN_THREE;
      end
      rmpd_pkg::NIB_IX2: begin
        base  = rmpd_pkg::CYC_IX2;
        d.len = rmpd_pkg::LEN_THREE;
      end
      rmpd_pkg::NIB_IX1: begin
        base  = rmpd_pkg::CYC_IX1;
        d.len = rmpd_pkg::LEN_TWO;
      end
      rmpd_pkg::NIB_IX0: begin
        base  = rmpd_pkg::CYC_IX0;
        d.len = rmpd_pkg::LEN_ONE;
      end
      default: begin
        d.legal = 1'b0;
      end
    endcase
    // sbc, adc, eor, cmp, cpx, bit share the arithmetic timing
    unique case (d.op)
      rmpd_pkg::RMPD_STACC, rmpd_pkg::RMPD_STIDX: d.cycles = base + rmpd_pkg::CYC_STORE_ADD;
      rmpd_pkg::RMPD_JUMP:                        d.cycles = base - rmpd_pkg::CYC_JUMP_SUB;
      rmpd_pkg::RMPD_CALL:                        d.cycles = base + rmpd_pkg::CYC_CALL_ADD;
      default:                                    d.cycles = base;
    endcase
    if (d.opcode == rmpd_pkg::OPC_PRODUCT) begin
      d.legal  = 1'b1;
      d.op     = rmpd_pkg::RMPD_PRODUCT;
      d.len    = rmpd_pkg::LEN_ONE;
      d.cycles = rmpd_pkg::CYC_PRODUCT;
    end
  end

endmodule

// ---- design/rmpd_core.sv ----
// register/memory and product execute unit with cycle timing
`timescale 1ns/1ps
module rmpd_core (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic [7:0] i_opcode,
  input  wire logic [7:0] i_operand,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_illegal,
  output logic [1:0]      o_len,
  output logic [3:0]      o_cycles,
  output logic [7:0]      o_acc,
  output logic [7:0]      o_idx,
  output logic            o_flag_h,
  output logic            o_flag_i,
  output logic            o_flag_n,
  output logic            o_flag_z,
  output logic            o_flag_c
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  rmpd_dec_if dif ();
  assign dif.opcode = i_opcode;

  rmpd_decode u_dec (
    .d (dif.dec)
  );

  typedef enum logic [0:0] {
    RMPD_IDLE = 1'b0,
    RMPD_EXEC = 1'b1
  } rmpd_state_t;

  rmpd_state_t        state;
  rmpd_pkg::rmpd_op_t op;
  logic [7:0]         mem;
  logic [3:0]         cnt;
  logic               take;
  logic               finish;

  assign take   = i_start && (state == RMPD_IDLE);
  assign finish = (state == RMPD_EXEC) && (cnt == 4'd1);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= RMPD_IDLE;
      cnt   <= 4'h0;
      op    <= rmpd_pkg::RMPD_SUB;
      mem   <= 8'h00;
    end else begin
      unique case (state)
        RMPD_IDLE: begin
          if (take && dif.legal) begin
            state <= RMPD_EXEC;
            cnt   <= dif.cycles - 4'd1;
            op    <= dif.op;
            mem   <= i_operand;
          end
        end
        RMPD_EXEC: begin
          if (finish) begin
            state <= RMPD_IDLE;
          end else begin
            cnt <= cnt - 4'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      o_illegal <= 1'b0;
      o_len     <= 2'd0;
      o_cycles  <= 4'h0;
    end else begin
      o_done    <= finish;
      o_illegal <= take && !dif.legal;
      if (take && dif.legal) begin
        o_busy   <= 1'b1;
        o_len    <= dif.len;
        o_cycles <= dif.cycles;
      end else if (finish) begin
        o_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  function automatic logic [8:0] subtract(input logic [7:0] a, input logic [7:0] m,
                                          input logic b);
    subtract = {1'b0, a} - {1'b0, m} - {8'h00, b};
  endfunction

  function automatic logic [8:0] add(input logic [7:0] a, input logic [7:0] m,
                                     input logic c);
    add = {1'b0, a} + {1'b0, m} + {8'h00, c};
  endfunction

  logic [7:0]  next_acc;
  logic [7:0]  next_idx;
  logic        next_h;
  logic        next_n;
  logic        next_z;
  logic        next_c;
  logic [8:0]  sum;
  logic [7:0]  res;
  logic [15:0] prod;

  always_comb begin
    next_acc = o_acc;
    next_idx = o_idx;
    next_h   = o_flag_h;
    next_n   = o_flag_n;
    next_z   = o_flag_z;
    next_c   = o_flag_c;
    sum      = 9'h000;
    res      = 8'h00;
    prod     = {8'h00, o_idx} * {8'h00, o_acc};
    unique case (op)
      rmpd_pkg::RMPD_SUB, rmpd_pkg::RMPD_CMPA, rmpd_pkg::RMPD_SBWB: begin
        sum = subtract(o_acc, mem, (op == rmpd_pkg::RMPD_SBWB) && o_flag_c);
        res = sum[7:0];
        next_c = sum[8];
        if (op != rmpd_pkg::RMPD_CMPA) begin
          next_acc = res;
        end
      end
      rmpd_pkg::RMPD_CMPX: begin
        sum    = subtract(o_idx, mem, 1'b0);
        res    = sum[7:0];
        next_c = sum[8];
      end
      rmpd_pkg::RMPD_ADD, rmpd_pkg::RMPD_ADWC: begin
        sum = add(o_acc, mem, (op == rmpd_pkg::RMPD_ADWC) && o_flag_c);
        res = sum[7:0];
        next_c   = sum[8];
        next_h   = (o_acc[4] ^ mem[4] ^ res[4]);
        next_acc = res;
      end
      rmpd_pkg::RMPD_AND, rmpd_pkg::RMPD_ANDTST: begin
        res = o_acc & mem;
        if (op == rmpd_pkg::RMPD_AND) begin
          next_acc = res;
        end
      end
      rmpd_pkg::RMPD_OR: begin
        res      = o_acc | mem;
        next_acc = res;
      end
      rmpd_pkg::RMPD_XOR: begin
        res      = o_acc ^ mem;
        next_acc = res;
      end
      rmpd_pkg::RMPD_LDACC: begin
        res      = mem;
        next_acc = res;
      end
      rmpd_pkg::RMPD_LDIDX: begin
        res      = mem;
        next_idx = res;
      end
      rmpd_pkg::RMPD_STACC: res = o_acc;
      rmpd_pkg::RMPD_STIDX: res = o_idx;
      rmpd_pkg::RMPD_PRODUCT: begin
        next_idx = prod[15:8];
        next_acc = prod[7:0];
        next_h   = 1'b0;
        next_c   = 1'b0;
      end
      default: res = 8'h00;
    endcase
    if (op != rmpd_pkg::RMPD_PRODUCT && op != rmpd_pkg::RMPD_JUMP &&
        op != rmpd_pkg::RMPD_CALL) begin
      next_n = res[7];
      next_z = (res == 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // programmer registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc    <= rmpd_pkg::RST_ACC;
      o_idx    <= rmpd_pkg::RST_IDX;
      o_flag_h <= rmpd_pkg::RST_FLAG;
      o_flag_i <= rmpd_pkg::RST_MASK;
      o_flag_n <= rmpd_pkg::RST_FLAG;
      o_flag_z <= rmpd_pkg::RST_FLAG;
      o_flag_c <= rmpd_pkg::RST_FLAG;
    end else if (finish) begin
      o_acc    <= next_acc;
      o_idx    <= next_idx;
      o_flag_h <= next_h;
      o_flag_n <= next_n;
      o_flag_z <= next_z;
      o_flag_c <= next_c;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_prod_start;
    take && i_opcode == rmpd_pkg::OPC_PRODUCT;
  endsequence

  sequence s_prod_run;
    o_busy[*8] ##1 o_busy[*2] ##1 (o_done && !o_busy);
  endsequence

  a_prod_value: assert property (
    s_prod_start |-> ##11 ({o_idx, o_acc} == $past(o_idx, 11) * $past(o_acc, 11)))
    else $error("product pair wrong");

  a_prod_split: assert property (
    s_prod_start |-> ##11 ({8'h00, o_idx} ==
      (({8'h00, $past(o_idx, 11)} * {8'h00, $past(o_acc, 11)}) >> 8)))
    else $error("product upper byte not in index");

  a_prod_flags: assert property (
    s_prod_start |-> ##11 (!o_flag_h && !o_flag_c && o_flag_i == $past(o_flag_i, 11)
                            && o_flag_n == $past(o_flag_n, 11)
                            && o_flag_z == $past(o_flag_z, 11)))
    else $error("product flags wrong");

  a_prod_timing: assert property (
    s_prod_start |=> (o_len == 2'd1 && o_cycles == 4'd11) ##0 s_prod_run)
    else $error("product length or timing wrong");

  a_mode_length: assert property (
    (take && dif.legal && i_opcode[7:4] == 4'hf) |=> o_len == 2'd1)
    else $error("no-offset indexed length wrong");

  a_sbc_timing: assert property (
    (take && i_opcode == 8'hd2) |=> o_busy[*4] ##1 (o_done && !o_busy))
    else $error("sbc 16-bit indexed timing wrong");

  a_adc_result: assert property (
    (take && i_opcode == 8'ha9) |-> ##2 (o_done &&
      o_acc == 8'($past(o_acc, 2) + $past(i_operand, 2) + {7'h00, $past(o_flag_c, 2)})))
    else $error("adc immediate result wrong");

  a_eor_result: assert property (
    (take && i_opcode == 8'hd8) |-> ##5 (o_done &&
      o_acc == ($past(o_acc, 5) ^ $past(i_operand, 5))))
    else $error("eor 16-bit indexed wrong");

  a_cmpa_flags: assert property (
    (take && i_opcode == 8'ha1) |-> ##2 (o_done && $stable(o_acc) &&
      o_flag_z == ($past(o_acc, 2) == $past(i_operand, 2))))
    else $error("compare accumulator wrong");

  a_cmpx_keep: assert property (
    (take && i_opcode == 8'hb3) |-> ##3 (o_done && $stable(o_idx) &&
      o_flag_c == ($past(o_idx, 3) < $past(i_operand, 3))))
    else $error("compare index wrong");

  a_bit_keep: assert property (
    (take && i_opcode == 8'ha5) |-> ##2 (o_done && $stable(o_acc) &&
      o_flag_z == (($past(o_acc, 2) & $past(i_operand, 2)) == 8'h00)))
    else $error("and test changed accumulator");

endmodule

// ---- tb/tb.sv ----
// self-checking testbench for the register/memory and product execute unit
`timescale 1ns/1ps
module tb;
  logic       i_clk;
  logic       i_rst_n;
  logic       i_start;
  logic [7:0] i_opcode;
  logic [7:0] i_operand;
  logic       o_busy;
  logic       o_done;
  logic       o_illegal;
  logic [1:0] o_len;
  logic [3:0] o_cycles;
  logic [7:0] o_acc;
  logic [7:0] o_idx;
  logic       o_flag_h;
  logic       o_flag_i;
  logic       o_flag_n;
  logic       o_flag_z;
  logic       o_flag_c;
  int         n_mismatch;
  int         n_tests;

  rmpd_core rmpd_core_i (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (i_start),
    .i_opcode  (i_opcode),
    .i_operand (i_operand),
    .o_busy    (o_busy),
    .o_done    (o_done),
    .o_illegal (o_illegal),
    .o_len     (o_len),
    .o_cycles  (o_cycles),
    .o_acc     (o_acc),
    .o_idx     (o_idx),
    .o_flag_h  (o_flag_h),
    .o_flag_i  (o_flag_i),
    .o_flag_n  (o_flag_n),
    .o_flag_z  (o_flag_z),
    .o_flag_c  (o_flag_c)
  );

  always #50 i_clk = ~i_clk;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_flags(input logic [4:0] exp);
    chk("flags hinzc", {11'h000, exp}, {11'h000, o_flag_h, o_flag_i, o_flag_n, o_flag_z, o_flag_c});
  endtask

  // offers one instruction, then counts edges from the take until done shows
  task automatic exec(input logic [7:0] op, input logic [7:0] opnd, input int n);
    int lat;
    @(posedge i_clk);
    i_start   <= 1'b1;
    i_opcode  <= op;
    i_operand <= opnd;
    @(posedge i_clk);
    i_start <= 1'b0;
    lat = 0;
    #1;
    while (o_done !== 1'b1 && lat < 20) begin
      @(posedge i_clk);
      #1;
      lat++;
    end
    chk("done latency", 16'(n - 1), 16'(lat));
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("acc", 16'h0000, {8'h00, o_acc});
    chk("idx", 16'h0000, {8'h00, o_idx});
    chk("busy", 16'h0000, {15'h0000, o_busy});
    chk_flags(5'b01000);
  endtask

  task automatic t_product;
    exec(8'ha6, 8'h0f, 2);
    exec(8'hab, 8'hf1, 2);
    chk_flags(5'b11011);
    exec(8'ha6, 8'hfe, 2);
    exec(8'hae, 8'hff, 2);
    exec(8'h42, 8'h00, 11);
    chk("product pair", 16'hfd02, {o_idx, o_acc});
    chk("product idx", 16'h00fd, {8'h00, o_idx});
    chk_flags(5'b01100);
    chk("product len", 16'h0001, {14'h0000, o_len});
    chk("product cycles", 16'h000b, {12'h000, o_cycles});
  endtask

  task automatic t_arith;
    exec(8'ha6, 8'h10, 2);
    exec(8'ha1, 8'h20, 2);
    chk("cmp acc", 16'h0010, {8'h00, o_acc});
    chk_flags(5'b01101);
    exec(8'ha2, 8'h05, 2);
    chk("sbc acc", 16'h000a, {8'h00, o_acc});
    chk_flags(5'b01000);
    exec(8'ha1, 8'hff, 2);
    exec(8'ha9, 8'h05, 2);
    chk("adc acc", 16'h0010, {8'h00, o_acc});
    chk_flags(5'b11000);
    exec(8'ha8, 8'hff, 2);
    chk("xor acc", 16'h00ef, {8'h00, o_acc});
    chk_flags(5'b11100);
    exec(8'hae, 8'h40, 2);
    exec(8'ha3, 8'h41, 2);
    chk("cpx pair", 16'h40ef, {o_idx, o_acc});
    chk_flags(5'b11101);
    exec(8'ha5, 8'h10, 2);
    chk("bit acc", 16'h00ef, {8'h00, o_acc});
    chk_flags(5'b11011);
  endtask

  task automatic t_timing;
    logic [3:0] lows [6];
    int         lens [6];
    int         cycs [6];
    lows = '{4'h2, 4'h9, 4'h8, 4'h1, 4'h3, 4'h5};
    lens = '{2, 2, 3, 3, 2, 1};
    cycs = '{2, 3, 4, 5, 4, 3};
    for (int l = 0; l < 6; l++) begin
      for (int m = 0; m < 6; m++) begin
        exec({4'(4'ha + m), lows[l]}, 8'h33, cycs[m]);
        chk("length", 16'(lens[m]), {14'h0000, o_len});
        chk("cycles", 16'(cycs[m]), {12'h000, o_cycles});
      end
    end
  endtask

  task automatic t_illegal;
    int pulses;
    int busy_seen;
    pulses = 0;
    busy_seen = 0;
    @(posedge i_clk);
    i_start  <= 1'b1;
    i_opcode <= 8'h00;
    @(posedge i_clk);
    i_start <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      #1;
      if (o_illegal === 1'b1) pulses++;
      if (o_busy !== 1'b0) busy_seen++;
      @(posedge i_clk);
    end
    chk("illegal pulses", 16'h0001, 16'(pulses));
    chk("illegal busy", 16'h0000, 16'(busy_seen));
  endtask

  // a start offered while busy must be ignored
  task automatic t_refuse;
    int lat;
    exec(8'ha6, 8'h07, 2);
    exec(8'hae, 8'h09, 2);
    @(posedge i_clk);
    i_start  <= 1'b1;
    i_opcode <= 8'h42;
    @(posedge i_clk);
    i_opcode  <= 8'ha6;
    i_operand <= 8'h55;
    repeat (3) @(posedge i_clk);
    i_start <= 1'b0;
    lat = 3;
    #1;
    while (o_done !== 1'b1 && lat < 20) begin
      @(posedge i_clk);
      #1;
      lat++;
    end
    chk("refused latency", 16'h000a, 16'(lat));
    chk("refused pair", 16'h003f, {o_idx, o_acc});
    chk("refused cycles", 16'h000b, {12'h000, o_cycles});
  endtask

  // stores, jumps and the remaining accumulator operations
  task automatic t_store_jump;
    exec(8'hb7, 8'h00, 4);
    chk("store len", 16'h0002, {14'h0000, o_len});
    exec(8'hcc, 8'h00, 3);
    chk("jump len", 16'h0003, {14'h0000, o_len});
    exec(8'hdd, 8'h00, 7);
    chk("call len", 16'h0003, {14'h0000, o_len});
    exec(8'hff, 8'h00, 4);
    chk("stx len", 16'h0001, {14'h0000, o_len});
    exec(8'ha6, 8'h3c, 2);
    exec(8'ha0, 8'h0c, 2);
    chk("sub acc", 16'h0030, {8'h00, o_acc});
    exec(8'ha4, 8'h18, 2);
    chk("and acc", 16'h0010, {8'h00, o_acc});
    exec(8'haa, 8'h05, 2);
    chk("or acc", 16'h0015, {8'h00, o_acc});
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clk      = 1'b0;
    i_rst_n    = 1'b0;
    i_start    = 1'b0;
    i_opcode   = 8'h00;
    i_operand  = 8'h00;
    n_mismatch = 0;
    n_tests    = 0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    t_reset;
    t_product;
    t_arith;
    t_timing;
    t_illegal;
    t_refuse;
    t_store_jump;
    wrap_up;
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    n_mismatch++;
    wrap_up;
  end
endmodule
